// file: logic/e1_sig_pkg.sv
// Purpose: shared constants for the time slot 16 signaling buffer block
// Assumes: 8-bit host register port, one 200 MHz clock
// Notes:   offsets are byte addresses on the host port
package e1_sig_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] SIG_BASE_ADDR  = 8'h30;
  localparam logic [7:0] SIG_LAST_ADDR  = 8'h3F;
  localparam int         SIG_REG_COUNT  = 16;
  localparam int         SIG_REG_WIDTH  = 8;
  localparam int         SIG_IDX_WIDTH  = 4;
  localparam int         SIG_TOTAL_BITS = SIG_REG_COUNT * SIG_REG_WIDTH;
  // ==========================================================
  // reset values
  localparam logic [7:0] SIG_RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
  localparam logic       READBACK_RESET  = 1'b0;
  // ==========================================================
  // buffering and timing
  localparam int         WR_FIFO_DEPTH       = 8;
  localparam int         WR_FIFO_WIDTH       = SIG_IDX_WIDTH + SIG_REG_WIDTH;
  localparam int         MULTIFRAME_TIME_US  = 2000;
  localparam int         CLOCK_MHZ           = 200;
  localparam int         MULTIFRAME_CYCLES   = MULTIFRAME_TIME_US * CLOCK_MHZ;
endpackage

// file: logic/sig_write_fifo.sv
// Purpose: small synchronous FIFO for host signaling writes
// Assumes: single clock, valid/ready on both sides
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module sig_write_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ==========================================================
  // state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [PW:0]                 count;
  } fifo_state_t;

  fifo_state_t cur_ff;
  fifo_state_t nxt_state;
  logic        push;
  logic        pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign inReady  = (cur_ff.count != (PW+1)'(DEPTH));
  assign outValid = (cur_ff.count != '0);
  assign outData  = cur_ff.mem[cur_ff.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // ==========================================================
  // next state
  always_comb begin
    nxt_state = cur_ff;
    if (push) begin
      nxt_state.mem[cur_ff.wrPtr] = inData;
      nxt_state.wrPtr             = bump(cur_ff.wrPtr);
    end
    if (pop) begin
      nxt_state.rdPtr = bump(cur_ff.rdPtr);
    end
    case ({push, pop})
      2'b10:   nxt_state.count = (PW+1)'(cur_ff.count + 1'b1);
      2'b01:   nxt_state.count = (PW+1)'(cur_ff.count - 1'b1);
      default: nxt_state.count = cur_ff.count;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end
endmodule
`default_nettype wire

// file: logic/e1_signaling_time_slot_signaling_buffers.sv
// Purpose: receive and transmit signaling buffers for time slot 16
// Assumes: bit strobes and boundary pulses come from framer logic on the same clock
// Notes:   host writes pass through a FIFO; reads answer one cycle after hostRdEn
`timescale 1ns/1ps
`default_nettype none
module e1_signaling_time_slot_signaling_buffers
  import e1_sig_pkg::*;
#(
  parameter int FIFO_DEPTH = e1_sig_pkg::WR_FIFO_DEPTH
) (
  input  wire logic                                clock,
  input  wire logic                                reset_n,
  // host register port
  input  wire logic [7:0]                          hostAddr,
  input  wire logic [e1_sig_pkg::SIG_REG_WIDTH-1:0] hostWrData,
  input  wire logic                                hostWrEn,
  output logic                                     hostWrReady,
  input  wire logic                                hostRdEn,
  output logic [e1_sig_pkg::SIG_REG_WIDTH-1:0]     hostRdData,
  // control and status bits
  input  wire logic                                txSignalingReadbackSel,
  input  wire logic                                txSignalingInsertEn,
  input  wire logic                                rxFlagClear,
  input  wire logic                                txFlagClear,
  output logic                                     rxMultiframeFlag,
  output logic                                     txMultiframeFlag,
  output logic                                     rxCasMultiframeEvent,
  output logic                                     txMultiframeEvent,
  // receive line side
  input  wire logic                                rxBitStrobe,
  input  wire logic                                rxBit,
  input  wire logic                                rxSignalingTimeSlot,
  input  wire logic                                rxMultiframeStart,
  // transmit line side
  input  wire logic                                txBitStrobe,
  input  wire logic                                txSignalingTimeSlot,
  input  wire logic                                txMultiframeStart,
  output logic                                     txSignalingBit,
  output logic                                     txSignalingInsert
);
  import e1_sig_pkg::*;

  // ==========================================================
  // state
  typedef logic [SIG_REG_COUNT-1:0][SIG_REG_WIDTH-1:0] sig_bank_t;

  typedef struct packed {
    logic [SIG_TOTAL_BITS-1:0] rxShift;
    sig_bank_t                 rxBuf;
    sig_bank_t                 txBuf;
    logic [SIG_TOTAL_BITS-1:0] txShift;
    logic [SIG_REG_WIDTH-1:0]  rdData;
    logic                      rxFlag;
    logic                      txFlag;
    logic                      rxEvent;
    logic                      txEvent;
    logic                      txBit;
    logic                      txInsert;
  } sig_state_t;

  sig_state_t cur_ff;
  sig_state_t nxt_state;

  // ==========================================================
  // address decode
  function automatic logic inSigRange(input logic [7:0] a);
    inSigRange = (a >= SIG_BASE_ADDR) && (a <= SIG_LAST_ADDR);
  endfunction

  function automatic logic [SIG_IDX_WIDTH-1:0] sigIndex(input logic [7:0] a);
    logic [7:0] d;
    d        = 8'(a - SIG_BASE_ADDR);
    sigIndex = d[SIG_IDX_WIDTH-1:0];
  endfunction

  // ==========================================================
  // host write FIFO
  logic                     fifoInValid;
  logic                     fifoInReady;
  logic                     fifoOutValid;
  logic                     fifoOutReady;
  logic [WR_FIFO_WIDTH-1:0] fifoOutData;
  logic [SIG_IDX_WIDTH-1:0] popIdx;
  logic [SIG_REG_WIDTH-1:0] popData;

  assign fifoInValid = hostWrEn && inSigRange(hostAddr);
  assign hostWrReady = fifoInReady;
  // the drain stalls in the boundary cycle so the load sees a stable buffer
  assign fifoOutReady = !txMultiframeStart;
  assign popIdx       = fifoOutData[WR_FIFO_WIDTH-1:SIG_REG_WIDTH];
  assign popData      = fifoOutData[SIG_REG_WIDTH-1:0];

  sig_write_fifo #(
    .WIDTH(WR_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   ({sigIndex(hostAddr), hostWrData}),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // ==========================================================
  // next state
  always_comb begin
    nxt_state         = cur_ff;
    nxt_state.rxEvent = 1'b0;
    nxt_state.txEvent = 1'b0;

    // receive: collect the time slot 16 bits of the running multiframe
    if (rxBitStrobe && rxSignalingTimeSlot) begin
      nxt_state.rxShift = {cur_ff.rxShift[SIG_TOTAL_BITS-2:0], rxBit};
    end
    // whole bank copied at the boundary only; alarm nibble kept as received
    if (rxMultiframeStart) begin
      nxt_state.rxBuf   = sig_bank_t'(cur_ff.rxShift);
      nxt_state.rxEvent = 1'b1;
    end
    // set wins over a clear in the same cycle
    if (rxMultiframeStart) begin
      nxt_state.rxFlag = 1'b1;
    end else if (rxFlagClear) begin
      nxt_state.rxFlag = 1'b0;
    end

    // transmit: host entries persist until rewritten
    if (fifoOutValid && fifoOutReady) begin
      nxt_state.txBuf[SIG_REG_COUNT-1-int'(popIdx)] = popData;
    end
    if (txMultiframeStart) begin
      nxt_state.txShift = SIG_TOTAL_BITS'(cur_ff.txBuf);
      nxt_state.txEvent = 1'b1;
    end else if (txBitStrobe && txSignalingTimeSlot) begin
      nxt_state.txShift = {cur_ff.txShift[SIG_TOTAL_BITS-2:0], 1'b0};
    end
    if (txBitStrobe && txSignalingTimeSlot) begin
      nxt_state.txBit = cur_ff.txShift[SIG_TOTAL_BITS-1];
    end
    nxt_state.txInsert = txSignalingInsertEn && txSignalingTimeSlot;
    if (txMultiframeStart) begin
      nxt_state.txFlag = 1'b1;
    end else if (txFlagClear) begin
      nxt_state.txFlag = 1'b0;
    end

    // host read, one cycle latency
    if (hostRdEn) begin
      if (!inSigRange(hostAddr)) begin
        nxt_state.rdData = READ_IDLE_VALUE;
      end else if (txSignalingReadbackSel) begin
        nxt_state.rdData = cur_ff.txBuf[SIG_REG_COUNT-1-int'(sigIndex(hostAddr))];
      end else begin
        nxt_state.rdData = cur_ff.rxBuf[SIG_REG_COUNT-1-int'(sigIndex(hostAddr))];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  // ==========================================================
  // outputs
  assign hostRdData           = cur_ff.rdData;
  assign rxMultiframeFlag     = cur_ff.rxFlag;
  assign txMultiframeFlag     = cur_ff.txFlag;
  assign rxCasMultiframeEvent = cur_ff.rxEvent;
  assign txMultiframeEvent    = cur_ff.txEvent;
  assign txSignalingBit       = cur_ff.txBit;
  assign txSignalingInsert    = cur_ff.txInsert;
endmodule
`default_nettype wire

// file: testbench/e1_sig_assertions.sv
// Purpose: port checks for the signaling buffer block
// Assumes: one clock, async active-low reset
// Notes:   bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module e1_sig_checker
  import e1_sig_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [7:0] hostAddr,
  input wire logic       hostRdEn,
  input wire logic [7:0] hostRdData,
  input wire logic       txSignalingReadbackSel,
  input wire logic       txSignalingInsertEn,
  input wire logic       rxMultiframeStart,
  input wire logic       txMultiframeStart,
  input wire logic       rxCasMultiframeEvent,
  input wire logic       txMultiframeEvent,
  input wire logic       rxMultiframeFlag,
  input wire logic       txMultiframeFlag,
  input wire logic       txSignalingInsert,
  input wire logic       txSignalingTimeSlot,
  input wire logic       txBitStrobe,
  input wire logic       txSignalingBit
);
  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_rx_event: assert property (rxMultiframeStart |=> rxCasMultiframeEvent) else $error("rx event late");
  a_rx_event_cause: assert property (rxCasMultiframeEvent |-> $past(rxMultiframeStart))
    else $error("rx event without boundary");
  a_rx_flag_set: assert property (rxMultiframeStart |=> rxMultiframeFlag) else $error("rx flag not set");
  a_tx_event: assert property (txMultiframeStart |=> txMultiframeEvent) else $error("tx event late");
  a_tx_flag_set: assert property (txMultiframeStart |=> txMultiframeFlag) else $error("tx flag not set");
  a_insert_gate: assert property (1'b1 |=> txSignalingInsert == $past(txSignalingInsertEn && txSignalingTimeSlot))
    else $error("insert flag wrong");
  a_read_range: assert property (hostRdEn && (hostAddr < SIG_BASE_ADDR || hostAddr > SIG_LAST_ADDR)
    |=> hostRdData == READ_IDLE_VALUE) else $error("unmapped read not idle");
  a_read_hold: assert property (!hostRdEn |=> $stable(hostRdData)) else $error("read data moved");
  // same rx buffer address read twice with no receive boundary between must agree
  a_rx_steady: assert property (hostRdEn && $past(hostRdEn) && $stable(hostAddr) && !txSignalingReadbackSel
    && !$past(txSignalingReadbackSel) && !$past(rxMultiframeStart) |=> $stable(hostRdData))
    else $error("rx buffer changed mid multiframe");
  a_txbit_hold: assert property (!(txBitStrobe && txSignalingTimeSlot) |=> $stable(txSignalingBit))
    else $error("tx bit moved without strobe");
endmodule
bind e1_signaling_time_slot_signaling_buffers e1_sig_checker chk_u (.clock(clock), .reset_n(reset_n), .hostAddr(hostAddr),
  .hostRdEn(hostRdEn), .hostRdData(hostRdData), .txSignalingReadbackSel(txSignalingReadbackSel),
  .txSignalingInsertEn(txSignalingInsertEn), .rxMultiframeStart(rxMultiframeStart),
  .txMultiframeStart(txMultiframeStart), .rxCasMultiframeEvent(rxCasMultiframeEvent),
  .txMultiframeEvent(txMultiframeEvent), .rxMultiframeFlag(rxMultiframeFlag), .txMultiframeFlag(txMultiframeFlag),
  .txSignalingInsert(txSignalingInsert), .txSignalingTimeSlot(txSignalingTimeSlot), .txBitStrobe(txBitStrobe),
  .txSignalingBit(txSignalingBit));
`default_nettype wire

// file: testbench/sig_line_model.sv
// Purpose: framer line side, time slot 16 bits both ways
// Assumes: driven at the falling edge
// Notes:   rxBit toggles between strobes so stale data is never seen
`timescale 1ns/1ps
`default_nettype none
module sig_line_model (
  input  wire logic clock,
  input  wire logic txSignalingBit,
  input  wire logic txSignalingInsert,
  input  wire logic txMultiframeEvent,
  output logic      rxBitStrobe,
  output logic      rxBit,
  output logic      rxSignalingTimeSlot,
  output logic      rxMultiframeStart,
  output logic      txBitStrobe,
  output logic      txSignalingTimeSlot,
  output logic      txMultiframeStart
);
  initial begin
    {rxBitStrobe, rxBit, rxSignalingTimeSlot, rxMultiframeStart} = 4'h0;
    {txBitStrobe, txSignalingTimeSlot, txMultiframeStart} = 3'h0;
  end
  // ==========================================================
  // one multiframe: boundary, then 128 slot bits
  task automatic run_mf(input logic [127:0] pat, output logic [127:0] seen, output logic ins, output logic ev);
    ins = 1'b0;
    @(negedge clock);
    rxMultiframeStart = 1'b1;
    txMultiframeStart = 1'b1;
    @(negedge clock);
    rxMultiframeStart = 1'b0;
    txMultiframeStart = 1'b0;
    ev = txMultiframeEvent;
    for (int i = 127; i >= 0; i--) begin
      @(negedge clock);
      {rxBitStrobe, txBitStrobe, rxSignalingTimeSlot, txSignalingTimeSlot} = 4'hF;
      rxBit = pat[i];
      @(negedge clock);
      {rxBitStrobe, txBitStrobe, rxSignalingTimeSlot, txSignalingTimeSlot} = 4'h0;
      rxBit = ~rxBit;
      seen[i] = txSignalingBit;
      ins = ins | txSignalingInsert;
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: register and line tests of the signaling buffers
// Assumes: inputs move at the falling edge
// Notes:   a write racing the transmit boundary is checked on the outgoing stream
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import e1_sig_pkg::*;
  logic         clock, reset_n, hostWrEn, hostWrReady, hostRdEn, rdSel, insEn, rxClr, txClr;
  logic         rxFlag, txFlag, rxEv, txEv, rxStb, rxBit, rxTs, rxMf, txStb, txTs, txMf, txBit, txIns, ins, ev;
  logic [7:0]   hostAddr, hostWrData, hostRdData;
  logic [127:0] txPat, rxPat, seen;
  int           fails, compares, cycles;
  e1_signaling_time_slot_signaling_buffers dut_u (.clock(clock), .reset_n(reset_n), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWrEn(hostWrEn), .hostWrReady(hostWrReady), .hostRdEn(hostRdEn),
    .hostRdData(hostRdData), .txSignalingReadbackSel(rdSel), .txSignalingInsertEn(insEn), .rxFlagClear(rxClr),
    .txFlagClear(txClr), .rxMultiframeFlag(rxFlag), .txMultiframeFlag(txFlag), .rxCasMultiframeEvent(rxEv),
    .txMultiframeEvent(txEv), .rxBitStrobe(rxStb), .rxBit(rxBit), .rxSignalingTimeSlot(rxTs),
    .rxMultiframeStart(rxMf), .txBitStrobe(txStb), .txSignalingTimeSlot(txTs), .txMultiframeStart(txMf),
    .txSignalingBit(txBit), .txSignalingInsert(txIns));
  sig_line_model line_u (.clock(clock), .txSignalingBit(txBit), .txSignalingInsert(txIns),
    .txMultiframeEvent(txEv), .rxBitStrobe(rxStb), .rxBit(rxBit), .rxSignalingTimeSlot(rxTs),
    .rxMultiframeStart(rxMf), .txBitStrobe(txStb), .txSignalingTimeSlot(txTs), .txMultiframeStart(txMf));
  // ==========================================================
  // tasks
  function automatic logic [7:0] w(input int i);
    return {4'(i), 4'(15 - i)}; // alignment nibble zero in the first word, alarm bits set
  endfunction
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock);
    hostWrEn = 1'b1;
    hostAddr = a;
    hostWrData = d;
    while (hostWrReady !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    hostWrEn = 1'b0;
  endtask
  // two reads back to back: both must agree
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    hostRdEn = 1'b1;
    hostAddr = a;
    @(negedge clock);
    check("read data", e, hostRdData);
    @(negedge clock);
    hostRdEn = 1'b0;
    check("reread data", e, hostRdData);
  endtask
  task automatic test_done();
    $display("counts fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // clock, timeout, sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {reset_n, hostWrEn, hostRdEn, rdSel, rxClr, txClr} = 6'h00;
    {hostAddr, hostWrData} = 16'h0000;
    insEn = 1'b1;
    {fails, compares, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    check("write ready", 128'(1'b1), 128'(hostWrReady));
    for (int i = 0; i < 16; i++) rd(8'(8'h30 + i), 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(8'(8'h30 + i), w(i));
      txPat[127 - 8 * i -: 8] = w(i);
      rxPat[127 - 8 * i -: 8] = ~w(i);
    end
    wr(8'h40, 8'hFF);
    rdSel = 1'b1;
    for (int i = 0; i < 16; i++) rd(8'(8'h30 + i), w(i));
    rd(8'h2F, 8'h00);
    $display("test registers done");
    line_u.run_mf(rxPat, seen, ins, ev);
    check("tx stream", txPat, seen);
    check("insert", 128'(1'b1), 128'(ins));
    check("tx event", 128'(1'b1), 128'(ev));
    check("flags", 128'(2'b11), 128'({rxFlag, txFlag}));
    {rxClr, txClr} = 2'b11;
    @(negedge clock);
    {rxClr, txClr} = 2'b00;
    @(negedge clock);
    check("flags cleared", 128'(2'b00), 128'({rxFlag, txFlag}));
    $display("test first multiframe done");
    rdSel = 1'b0;
    insEn = 1'b0;
    line_u.run_mf(~rxPat, seen, ins, ev);
    check("tx repeat", txPat, seen);
    check("no insert", 128'(1'b0), 128'(ins));
    for (int i = 0; i < 16; i++) rd(8'(8'h30 + i), ~w(i));
    $display("test second multiframe done");
    // write taken one cycle before the boundary: the drain stalls there, so it goes out a multiframe later
    insEn = 1'b1;
    fork
      wr(8'h31, 8'hA5);
      begin
        @(negedge clock);
        line_u.run_mf(rxPat, seen, ins, ev);
      end
    join
    check("tx collide", txPat, seen);
    txPat[119 -: 8] = 8'hA5;
    line_u.run_mf(rxPat, seen, ins, ev);
    check("tx late write", txPat, seen);
    $display("test boundary write done");
    test_done();
  end
endmodule
`default_nettype wire
